/* src/lec_pkg.sv */
// Constants and types for the link enhancement control block
package lec_pkg;
  localparam logic [11:0] LEC_SET_OFS       = 12'ha88;
  localparam logic [11:0] LEC_CLR_OFS       = 12'ha8c;
  localparam logic [7:0]  LEC_CFG_OFS       = 8'hf4;
  localparam logic [31:0] LEC_RESET_VAL     = 32'h00001000;
  localparam logic [31:0] LEC_WR_MASK       = 32'h0000b500;
  localparam logic [31:0] LEC_EEPROM_MASK   = 32'h0000b500;
  localparam int          LEC_DIS_REORDER_B = 15;
  localparam int          LEC_THR_LO_B      = 12;
  localparam int          LEC_MPEG_TS_B     = 10;
  localparam int          LEC_DV_TS_B       = 8;
  localparam logic [7:0]  LEC_FMT_MPEG      = 8'h20;
  localparam logic [7:0]  LEC_FMT_DV        = 8'h00;
  localparam logic [11:0] LEC_THR_2K        = 12'h800;
  localparam logic [11:0] LEC_THR_1K7       = 12'h6c0;
  localparam logic [11:0] LEC_THR_1K        = 12'h400;
  localparam logic [11:0] LEC_THR_512       = 12'h200;
  typedef enum logic [1:0] {
    LEC_THR_SEL_2K  = 2'h0,
    LEC_THR_SEL_1K7 = 2'h1,
    LEC_THR_SEL_1K  = 2'h2,
    LEC_THR_SEL_512 = 2'h3
  } lec_thr_sel_type;
  typedef enum {LEC_TX_IDLE, LEC_TX_FILL, LEC_TX_SEND} lec_tx_state_type;
endpackage

/* src/lec_threshold_dec.sv */
// Transmit start threshold decoder
`timescale 1ns/100ps
module lec_threshold_dec
  import lec_pkg::*;
(
  input  wire logic [1:0]  thr_sel,
  input  wire logic        force_sf,
  output logic      [11:0] thr_bytes,
  output logic             sf_mode
);
  always_comb begin
    sf_mode = force_sf;
    case (thr_sel)
      LEC_THR_SEL_2K:  begin
        thr_bytes = LEC_THR_2K;
        sf_mode   = 1'b1;
      end
      LEC_THR_SEL_1K7: thr_bytes = LEC_THR_1K7;
      LEC_THR_SEL_1K:  thr_bytes = LEC_THR_1K;
      LEC_THR_SEL_512: thr_bytes = LEC_THR_512;
      default:         thr_bytes = LEC_THR_2K;
    endcase
    if (force_sf) begin
      thr_bytes = LEC_THR_2K;
    end
  end
endmodule

/* src/lec_link_enhancement.sv */
// Link enhancement set/clear register and async transmit start control
`timescale 1ns/100ps
module lec_link_enhancement
  import lec_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        MEM_WR,
  input  wire logic        MEM_RD,
  input  wire logic [11:0] MEM_ADDR,
  input  wire logic [31:0] MEM_WDATA,
  output logic      [31:0] MEM_RDATA,
  input  wire logic        CFG_WR,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  input  wire logic        EEPROM_LOAD,
  input  wire logic [31:0] EEPROM_DATA,
  input  wire logic        RETRIES_ZERO,
  input  wire logic        PKT_START,
  input  wire logic        PKT_EOP,
  input  wire logic        PKT_RETRY,
  input  wire logic        FIFO_EMPTY,
  input  wire logic [11:0] FIFO_LEVEL,
  input  wire logic [7:0]  STREAM_FORMAT_CODE,
  output logic             TX_GO,
  output logic             TX_UNDERRUN,
  output logic             SF_ACTIVE,
  output logic             DISABLE_TX_REORDER,
  output logic             MPEG_TS_ACTIVE,
  output logic             DV_TS_ACTIVE
);
  logic [31:0]      ctl_r;
  logic [31:0]      ctl_nxt;
  logic             sf_latch_r;
  logic             sf_latch_nxt;
  logic             under_r;
  logic             under_nxt;
  lec_tx_state_type st_r;
  lec_tx_state_type st_nxt;
  logic [31:0]      rd_r;
  logic [31:0]      rd_nxt;
  logic             eop_seen_r;
  logic             eop_seen_nxt;
  logic [11:0]      thr_bytes;
  logic             sf_mode;

  lec_threshold_dec u_dec (
    .thr_sel   (ctl_r[LEC_THR_LO_B+1:LEC_THR_LO_B]),
    .force_sf  (sf_latch_r | RETRIES_ZERO),
    .thr_bytes (thr_bytes),
    .sf_mode   (sf_mode)
  );

  // Register file
  always_comb begin
    ctl_nxt = ctl_r;
    if (EEPROM_LOAD) begin
      ctl_nxt = (ctl_r & ~LEC_EEPROM_MASK) | (EEPROM_DATA & LEC_EEPROM_MASK);
    end
    if (MEM_WR && MEM_ADDR == LEC_SET_OFS) begin
      ctl_nxt = ctl_nxt | (MEM_WDATA & LEC_WR_MASK);
    end else if (MEM_WR && MEM_ADDR == LEC_CLR_OFS) begin
      ctl_nxt = ctl_nxt & ~(MEM_WDATA & LEC_WR_MASK);
    end
    if (CFG_WR && CFG_ADDR == LEC_CFG_OFS) begin
      ctl_nxt = CFG_WDATA & LEC_WR_MASK;
    end
    ctl_nxt = ctl_nxt & LEC_WR_MASK;
    rd_nxt = 32'h00000000;
    if (MEM_RD && (MEM_ADDR == LEC_SET_OFS || MEM_ADDR == LEC_CLR_OFS)) begin
      rd_nxt = ctl_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ctl_r <= LEC_RESET_VAL;
      rd_r  <= 32'h00000000;
    end else begin
      ctl_r <= ctl_nxt;
      rd_r  <= rd_nxt;
    end
  end

  assign MEM_RDATA = rd_r;
  assign CFG_RDATA = (CFG_ADDR == LEC_CFG_OFS) ? ctl_r : 32'h00000000;

  // Transmit start control
  always_comb begin
    st_nxt       = st_r;
    sf_latch_nxt = sf_latch_r;
    under_nxt    = 1'b0;
    eop_seen_nxt = eop_seen_r;
    case (st_r)
      LEC_TX_IDLE: begin
        eop_seen_nxt = 1'b0;
        if (PKT_START) begin
          st_nxt       = LEC_TX_FILL;
          eop_seen_nxt = PKT_EOP;
        end
      end
      LEC_TX_FILL: begin
        if (PKT_EOP) begin
          eop_seen_nxt = 1'b1;
        end
        if (eop_seen_r || PKT_EOP) begin
          st_nxt = LEC_TX_SEND;
        end else if (!sf_mode && FIFO_LEVEL >= thr_bytes) begin
          st_nxt = LEC_TX_SEND;
        end
      end
      LEC_TX_SEND: begin
        if (PKT_EOP) begin
          eop_seen_nxt = 1'b1;
        end
        if (FIFO_EMPTY && !eop_seen_r && !PKT_EOP) begin
          under_nxt    = 1'b1;
          sf_latch_nxt = 1'b1;
          st_nxt       = LEC_TX_IDLE;
        end else if (FIFO_EMPTY && eop_seen_r) begin
          st_nxt = LEC_TX_IDLE;
        end
      end
      default: st_nxt = LEC_TX_IDLE;
    endcase
    if (PKT_RETRY) begin
      sf_latch_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r       <= LEC_TX_IDLE;
      sf_latch_r <= 1'b0;
      under_r    <= 1'b0;
      eop_seen_r <= 1'b0;
    end else begin
      st_r       <= st_nxt;
      sf_latch_r <= sf_latch_nxt;
      under_r    <= under_nxt;
      eop_seen_r <= eop_seen_nxt;
    end
  end

  assign TX_GO              = (st_r == LEC_TX_SEND);
  assign TX_UNDERRUN        = under_r;
  assign SF_ACTIVE          = sf_mode;
  assign DISABLE_TX_REORDER = ctl_r[LEC_DIS_REORDER_B];
  assign MPEG_TS_ACTIVE     = ctl_r[LEC_MPEG_TS_B] && STREAM_FORMAT_CODE == LEC_FMT_MPEG;
  assign DV_TS_ACTIVE       = ctl_r[LEC_DV_TS_B] && STREAM_FORMAT_CODE == LEC_FMT_DV;

  // Checks
  property p_rsvd_zero;
    @(posedge CLK) disable iff (RST) (ctl_r & ~LEC_WR_MASK) == 32'h00000000;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("Reserved bits set");

  property p_set;
    @(posedge CLK) disable iff (RST)
      (MEM_WR && MEM_ADDR == LEC_SET_OFS && !CFG_WR && !EEPROM_LOAD)
      |=> ((ctl_r & ($past(MEM_WDATA) & LEC_WR_MASK)) == ($past(MEM_WDATA) & LEC_WR_MASK));
  endproperty
  a_set: assert property (p_set) else $error("Set write failed");

  property p_clr;
    @(posedge CLK) disable iff (RST)
      (MEM_WR && MEM_ADDR == LEC_CLR_OFS && !CFG_WR && !EEPROM_LOAD)
      |=> ((ctl_r & $past(MEM_WDATA)) == 32'h00000000);
  endproperty
  a_clr: assert property (p_clr) else $error("Clear write failed");

  property p_read;
    @(posedge CLK) disable iff (RST)
      (MEM_RD && MEM_ADDR == LEC_CLR_OFS) |=> MEM_RDATA == $past(ctl_r);
  endproperty
  a_read: assert property (p_read) else $error("Read value wrong");

  property p_reorder;
    @(posedge CLK) disable iff (RST)
      (MEM_WR && MEM_ADDR == LEC_SET_OFS && MEM_WDATA[15] && !CFG_WR) |=> DISABLE_TX_REORDER;
  endproperty
  a_reorder: assert property (p_reorder) else $error("Reorder disable wrong");

  property p_sf_retry;
    @(posedge CLK) disable iff (RST) PKT_RETRY |=> SF_ACTIVE;
  endproperty
  a_sf_retry: assert property (p_sf_retry) else $error("Retry not store-forward");

  property p_retries_zero;
    @(posedge CLK) disable iff (RST) RETRIES_ZERO |-> SF_ACTIVE && thr_bytes == LEC_THR_2K;
  endproperty
  a_retries_zero: assert property (p_retries_zero) else $error("Forced store-forward missed");

  property p_underrun;
    @(posedge CLK) disable iff (RST)
      (st_r == LEC_TX_SEND && FIFO_EMPTY && !eop_seen_r && !PKT_EOP)
      |=> TX_UNDERRUN && SF_ACTIVE ##1 !TX_UNDERRUN;
  endproperty
  a_underrun: assert property (p_underrun) else $error("Underrun not handled");

  property p_sf_hold;
    @(posedge CLK) disable iff (RST)
      (st_r == LEC_TX_FILL && sf_mode && !eop_seen_r && !PKT_EOP) |=> !TX_GO;
  endproperty
  a_sf_hold: assert property (p_sf_hold) else $error("Sent before end of packet");

  property p_mpeg;
    @(posedge CLK) disable iff (RST)
      (MEM_WR && MEM_ADDR == LEC_SET_OFS && MEM_WDATA[10] && !CFG_WR)
      |=> MPEG_TS_ACTIVE == (STREAM_FORMAT_CODE == 8'h20);
  endproperty
  a_mpeg: assert property (p_mpeg) else $error("MPEG enable wrong");
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the link enhancement control block
`timescale 1ns/100ps
module tb_top;
  import lec_pkg::*;
  logic        CLK, RST, MEM_WR, MEM_RD, CFG_WR, EEPROM_LOAD, RETRIES_ZERO;
  logic        PKT_START, PKT_EOP, PKT_RETRY, FIFO_EMPTY;
  logic [11:0] MEM_ADDR, FIFO_LEVEL;
  logic [31:0] MEM_WDATA, MEM_RDATA, CFG_WDATA, CFG_RDATA, EEPROM_DATA;
  logic [7:0]  CFG_ADDR, STREAM_FORMAT_CODE;
  logic        TX_GO, TX_UNDERRUN, SF_ACTIVE, DISABLE_TX_REORDER, MPEG_TS_ACTIVE, DV_TS_ACTIVE;
  int          n_errors, comparisons, cycles;

  lec_link_enhancement i_dut (.CLK, .RST, .MEM_WR, .MEM_RD, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA,
    .CFG_WR, .CFG_ADDR, .CFG_WDATA, .CFG_RDATA, .EEPROM_LOAD, .EEPROM_DATA, .RETRIES_ZERO,
    .PKT_START, .PKT_EOP, .PKT_RETRY, .FIFO_EMPTY, .FIFO_LEVEL, .STREAM_FORMAT_CODE, .TX_GO,
    .TX_UNDERRUN, .SF_ACTIVE, .DISABLE_TX_REORDER, .MPEG_TS_ACTIVE, .DV_TS_ACTIVE);

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task automatic end_sim();
    if (n_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard, well above the 108 cycles needed
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge CLK);
  endtask

  task automatic mwr(input logic [11:0] a, input logic [31:0] d);
    MEM_ADDR = a;
    MEM_WDATA = d;
    MEM_WR = 1'b1;
    cyc(1);
    MEM_WR = 1'b0;
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    MEM_ADDR = a;
    MEM_RD = 1'b1;
    cyc(1);
    MEM_RD = 1'b0;
    chk(what, exp, MEM_RDATA);
  endtask

  // Program threshold by config alias, then run one packet through
  task automatic pkt(input logic [1:0] sel, input logic [11:0] lvl, input logic go);
    CFG_WDATA = {18'h0, sel, 12'h0};
    CFG_WR = 1'b1;
    cyc(1);
    CFG_WR = 1'b0;
    PKT_START = 1'b1;
    FIFO_LEVEL = lvl - 12'h1;
    cyc(1);
    PKT_START = 1'b0;
    cyc(2);
    chk("tx_go below level", 32'h0, TX_GO);
    FIFO_LEVEL = lvl;
    cyc(2);
    chk("tx_go at level", go, TX_GO);
    PKT_EOP = 1'b1;
    cyc(1);
    PKT_EOP = 1'b0;
    cyc(1);
    chk("tx_go after end token", 32'h1, TX_GO);
    FIFO_EMPTY = 1'b1;
    cyc(2);
    chk("tx_go after drain", 32'h0, TX_GO);
    FIFO_EMPTY = 1'b0;
  endtask

  task automatic t_regs();
    rdchk("reset value", 12'ha88, LEC_RESET_VAL);
    mwr(12'ha88, 32'hffffffff);
    rdchk("set all", 12'ha8c, 32'h0000b500);
    chk("reorder off", 32'h1, DISABLE_TX_REORDER);
    chk("config alias", 32'h0000b500, CFG_RDATA);
    CFG_ADDR = 8'hf0;
    cyc(1);
    chk("config unmapped", 32'h0, CFG_RDATA);
    CFG_ADDR = LEC_CFG_OFS;
    mwr(12'ha8c, 32'h00008000);
    rdchk("clear one", 12'ha88, 32'h00003500);
    chk("reorder on", 32'h0, DISABLE_TX_REORDER);
    mwr(12'ha8c, 32'hffffffff);
    rdchk("clear all", 12'ha88, 32'h0);
    rdchk("unmapped", 12'ha90, 32'h0);
  endtask

  task automatic t_stamp();
    logic [7:0] fmts [3] = '{8'h20, 8'h00, 8'h01};
    mwr(12'ha88, 32'h00000500);
    for (int i = 0; i < 3; i++) begin
      STREAM_FORMAT_CODE = fmts[i];
      cyc(1);
      chk("mpeg stamp", fmts[i] == 8'h20, MPEG_TS_ACTIVE);
      chk("dv stamp", fmts[i] == 8'h00, DV_TS_ACTIVE);
    end
    STREAM_FORMAT_CODE = 8'h00;
    mwr(12'ha8c, 32'h00000100);
    chk("dv stamp off", 32'h0, DV_TS_ACTIVE);
  endtask

  task automatic t_eeprom();
    EEPROM_DATA = 32'hffffffff;
    EEPROM_LOAD = 1'b1;
    cyc(1);
    EEPROM_LOAD = 1'b0;
    rdchk("eeprom load", 12'ha88, LEC_EEPROM_MASK);
  endtask

  task automatic t_thr();
    logic [11:0] th [4] = '{12'h800, 12'h6c0, 12'h400, 12'h200};
    for (int s = 0; s < 4; s++) begin
      pkt(s[1:0], th[s], s != 0);
    end
  endtask

  task automatic t_retries();
    RETRIES_ZERO = 1'b1;
    cyc(1);
    chk("forced store-forward", 32'h1, SF_ACTIVE);
    pkt(2'h3, 12'h200, 1'b0);
    RETRIES_ZERO = 1'b0;
    cyc(1);
    chk("store-forward released", 32'h0, SF_ACTIVE);
  endtask

  task automatic t_underrun();
    logic seen;
    seen = 1'b0;
    CFG_WDATA = 32'h00002000;
    CFG_WR = 1'b1;
    cyc(1);
    CFG_WR = 1'b0;
    PKT_START = 1'b1;
    FIFO_LEVEL = 12'h400;
    cyc(1);
    PKT_START = 1'b0;
    cyc(2);
    chk("tx_go at 1k", 32'h1, TX_GO);
    FIFO_EMPTY = 1'b1;
    repeat (3) begin
      cyc(1);
      if (TX_UNDERRUN === 1'b1) seen = 1'b1;
    end
    chk("underrun pulse", 32'h1, seen);
    chk("store-forward latched", 32'h1, SF_ACTIVE);
    FIFO_EMPTY = 1'b0;
    cyc(1);
    pkt(2'h2, 12'h400, 1'b0);
  endtask

  // Mid-run reset clears the latch, then a retry alone forces store-and-forward
  task automatic t_retry();
    RST = 1'b1;
    cyc(2);
    RST = 1'b0;
    chk("store-forward after reset", 32'h0, SF_ACTIVE);
    rdchk("value after reset", 12'ha8c, LEC_RESET_VAL);
    PKT_RETRY = 1'b1;
    cyc(1);
    PKT_RETRY = 1'b0;
    chk("store-forward on retry", 32'h1, SF_ACTIVE);
    pkt(2'h1, 12'h6c0, 1'b0);
  endtask

  initial begin
    {MEM_WR, MEM_RD, CFG_WR, EEPROM_LOAD, RETRIES_ZERO, PKT_START, PKT_EOP} = '0;
    {PKT_RETRY, FIFO_EMPTY, MEM_ADDR, FIFO_LEVEL, MEM_WDATA, CFG_WDATA, EEPROM_DATA} = '0;
    STREAM_FORMAT_CODE = 8'h00;
    CFG_ADDR = LEC_CFG_OFS;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    RST = 1'b1;
    cyc(8);
    RST = 1'b0;
    t_regs();
    t_stamp();
    t_eeprom();
    t_thr();
    t_retries();
    t_underrun();
    t_retry();
    end_sim();
  end
endmodule
